// >>> inc/ccs_pkg.sv
// package: cpu clock source switch constants and carriers
package ccs_pkg;
  // oscillator mode register fields
  localparam int OSC_EXT_SEL_BIT = 7;
  localparam int OSC_PIN_SEL_BIT = 6;
  localparam int OSC_AMP_BIT = 0;
  // main oscillator control register
  localparam int MOC_HALT_BIT = 7;
  // main clock mode register
  localparam int MCM_PATH_BIT = 2;
  localparam int MCM_STATE_BIT = 1;
  localparam int MCM_SRC_BIT = 0;
  // internal oscillator mode register
  localparam int ROSC_STATE_BIT = 7;
  localparam int ROSC_HALT_BIT = 0;
  // cpu clock control register
  localparam int CPU_SRC_BIT = 4;
  localparam int CPU_STATE_BIT = 5;
  // register write select codes
  localparam logic [2:0] SEL_OSC = 3'h0;
  localparam logic [2:0] SEL_MOC = 3'h1;
  localparam logic [2:0] SEL_MCM = 3'h2;
  localparam logic [2:0] SEL_ROSC = 3'h3;
  localparam logic [2:0] SEL_CPU = 3'h4;
  // reset values
  localparam logic [7:0] OSC_RESET = 8'h00;
  localparam logic [7:0] MOC_RESET = 8'h80;
  localparam logic [7:0] MCM_RESET = 8'h00;
  localparam logic [7:0] ROSC_RESET = 8'h00;
  localparam logic [7:0] CPU_RESET = 8'h01;
  // timing at 20 MHz
  localparam int CLK_MHZ = 20;
  localparam int AMP_GAP_NS = 5000;
  localparam int AMP_GAP_CYC = (AMP_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_PROC_NS = 20000;
  localparam int RST_PROC_CYC = (RST_PROC_NS * CLK_MHZ) / 1000;
  localparam int CNT_W = 10;
  typedef enum logic [2:0] {
    ST_PRE_RESET = 3'h0,
    ST_RESET_PROC = 3'h1,
    ST_INT_OSC = 3'h2,
    ST_SYS_CLK = 3'h3,
    ST_HALT = 3'h4,
    ST_STOP = 3'h5
  } ccs_state_type;
  typedef struct packed {
    logic wr;
    logic [2:0] sel;
    logic [7:0] data;
  } ccs_wr_type;
endpackage

// >>> verilog/ccs_cycle_timer.sv
// down counter that reports when a loaded cycle count has elapsed
`timescale 1ns/1ps
module ccs_cycle_timer #(
  parameter int WIDTH = 10
) (
  // clock and control
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // load and status
  input wire logic load_in,
  input wire logic [WIDTH-1:0] count_in,
  output logic busy_out
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  always_comb begin
    next_count = count;
    if (load_in) begin
      next_count = count_in;
    end else if (count != '0) begin
      next_count = count - WIDTH'(1);
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      count <= '0;
    end else if (clk_en_in) begin
      count <= next_count;
    end
  end
  assign busy_out = (count != '0);
endmodule

// >>> verilog/ccs_clock_switch.sv
// cpu clock source sequencing with flag registers and state machine
// Functional notes
// - cpu starts on internal oscillator after reset
// - gain and path flags change once only
// - no return to internal oscillator clock
// - gain raise stalls cpu clock 5 us
// - halt instruction on system clock halts
// - voltage detect mode waits, 20 us reset
// - oscillator mode bits 7, 6, 0
// - main oscillator halt at bit 7
// - path bit 2, main select bit 0
// - internal status bit 7, halt bit 0
// - cpu source select at bit 4
// - one status flag (main clock mode bit 1) reports cpu clock; cpu register bit 5 reads 0
`timescale 1ns/1ps
module ccs_clock_switch (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // register write port
  input ccs_pkg::ccs_wr_type reg_wr_in,
  // cpu events and options
  input wire logic halt_instr_in,
  input wire logic stop_instr_in,
  input wire logic wake_in,
  input wire logic voltage_detect_option_in,
  input wire logic supply_trip_in,
  // register views
  output logic [7:0] osc_mode_reg_out,
  output logic [7:0] main_osc_ctrl_reg_out,
  output logic [7:0] main_clock_mode_reg_out,
  output logic [7:0] int_osc_mode_reg_out,
  output logic [7:0] cpu_clock_ctrl_reg_out,
  // clock control
  output logic cpu_clk_gate_out,
  output logic cpu_on_main_out,
  output logic main_osc_run_out,
  output logic int_osc_run_out,
  output logic [2:0] state_out
);
  logic [7:0] osc_reg, next_osc_reg;
  logic [7:0] moc_reg, next_moc_reg;
  logic [7:0] mcm_reg, next_mcm_reg;
  logic [7:0] rosc_reg, next_rosc_reg;
  logic [7:0] cpu_reg, next_cpu_reg;
  logic amp_done, next_amp_done;
  logic path_done, next_path_done;
  ccs_pkg::ccs_state_type state, next_state;
  logic amp_load, rst_load, gap_busy, proc_busy;
  logic wr_osc, wr_mcm;

  function automatic logic wr_hit(input ccs_pkg::ccs_wr_type w, input logic [2:0] s);
    wr_hit = w.wr && (w.sel == s);
  endfunction

  assign wr_osc = wr_hit(reg_wr_in, ccs_pkg::SEL_OSC);
  assign wr_mcm = wr_hit(reg_wr_in, ccs_pkg::SEL_MCM);
  // gain raised to 1 for the first time starts the cpu clock gap
  assign amp_load = wr_osc && !amp_done &&
                    reg_wr_in.data[ccs_pkg::OSC_AMP_BIT] && !osc_reg[ccs_pkg::OSC_AMP_BIT];

  ccs_cycle_timer #(.WIDTH(ccs_pkg::CNT_W)) u_gap (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .load_in(amp_load | rst_load),
    .count_in(amp_load ? ccs_pkg::CNT_W'(ccs_pkg::AMP_GAP_CYC)
                       : ccs_pkg::CNT_W'(ccs_pkg::RST_PROC_CYC)),
    .busy_out(gap_busy)
  );
  assign proc_busy = gap_busy;

  always_comb begin
    next_osc_reg = osc_reg;
    next_moc_reg = moc_reg;
    next_mcm_reg = mcm_reg;
    next_rosc_reg = rosc_reg;
    next_cpu_reg = cpu_reg;
    next_amp_done = amp_done;
    next_path_done = path_done;
    if (wr_osc) begin
      next_osc_reg[ccs_pkg::OSC_EXT_SEL_BIT] = reg_wr_in.data[ccs_pkg::OSC_EXT_SEL_BIT];
      next_osc_reg[ccs_pkg::OSC_PIN_SEL_BIT] = reg_wr_in.data[ccs_pkg::OSC_PIN_SEL_BIT];
      if (!amp_done) begin
        next_osc_reg[ccs_pkg::OSC_AMP_BIT] = reg_wr_in.data[ccs_pkg::OSC_AMP_BIT];
        next_amp_done = 1'b1;
      end
    end
    if (wr_hit(reg_wr_in, ccs_pkg::SEL_MOC)) begin
      next_moc_reg[ccs_pkg::MOC_HALT_BIT] = reg_wr_in.data[ccs_pkg::MOC_HALT_BIT];
    end
    if (wr_mcm) begin
      // main select cannot fall back once the cpu is on the main clock
      if (!mcm_reg[ccs_pkg::MCM_STATE_BIT]) begin
        next_mcm_reg[ccs_pkg::MCM_SRC_BIT] = reg_wr_in.data[ccs_pkg::MCM_SRC_BIT];
      end
      if (!path_done) begin
        next_mcm_reg[ccs_pkg::MCM_PATH_BIT] = reg_wr_in.data[ccs_pkg::MCM_PATH_BIT];
        next_path_done = 1'b1;
      end
    end
    if (wr_hit(reg_wr_in, ccs_pkg::SEL_ROSC)) begin
      next_rosc_reg[ccs_pkg::ROSC_HALT_BIT] = reg_wr_in.data[ccs_pkg::ROSC_HALT_BIT];
    end
    if (wr_hit(reg_wr_in, ccs_pkg::SEL_CPU)) begin
      next_cpu_reg[2:0] = reg_wr_in.data[2:0];
      next_cpu_reg[ccs_pkg::CPU_SRC_BIT] = reg_wr_in.data[ccs_pkg::CPU_SRC_BIT];
    end
    // status flag follows the switch; sticky so the cpu never returns
    next_mcm_reg[ccs_pkg::MCM_STATE_BIT] = mcm_reg[ccs_pkg::MCM_STATE_BIT] |
      (mcm_reg[ccs_pkg::MCM_SRC_BIT] & mcm_reg[ccs_pkg::MCM_PATH_BIT]);
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      osc_reg <= ccs_pkg::OSC_RESET;
      moc_reg <= ccs_pkg::MOC_RESET;
      mcm_reg <= ccs_pkg::MCM_RESET;
      rosc_reg <= ccs_pkg::ROSC_RESET;
      cpu_reg <= ccs_pkg::CPU_RESET;
      amp_done <= 1'b0;
      path_done <= 1'b0;
    end else if (clk_en_in) begin
      osc_reg <= next_osc_reg;
      moc_reg <= next_moc_reg;
      mcm_reg <= next_mcm_reg;
      rosc_reg <= next_rosc_reg;
      cpu_reg <= next_cpu_reg;
      amp_done <= next_amp_done;
      path_done <= next_path_done;
    end
  end

  // power-up sequence and cpu clock state
  always_comb begin
    next_state = state;
    rst_load = 1'b0;
    case (state)
      ccs_pkg::ST_PRE_RESET: begin
        if (!voltage_detect_option_in || supply_trip_in) begin
          next_state = ccs_pkg::ST_RESET_PROC;
          rst_load = 1'b1;
        end
      end
      ccs_pkg::ST_RESET_PROC: begin
        if (!proc_busy) begin
          next_state = ccs_pkg::ST_INT_OSC;
        end
      end
      ccs_pkg::ST_INT_OSC: begin
        // move with the status flag so state and flag never disagree
        if (next_mcm_reg[ccs_pkg::MCM_STATE_BIT]) begin
          next_state = ccs_pkg::ST_SYS_CLK;
        end
      end
      ccs_pkg::ST_SYS_CLK: begin
        if (stop_instr_in) begin
          next_state = ccs_pkg::ST_STOP;
        end else if (halt_instr_in) begin
          next_state = ccs_pkg::ST_HALT;
        end
      end
      ccs_pkg::ST_HALT, ccs_pkg::ST_STOP: begin
        if (wake_in) begin
          next_state = ccs_pkg::ST_SYS_CLK;
        end
      end
      default: begin
        next_state = ccs_pkg::ST_PRE_RESET;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state <= ccs_pkg::ST_PRE_RESET;
    end else if (clk_en_in) begin
      state <= next_state;
    end
  end

  // cpu runs only when active and no gap is pending; gap counts while gated
  assign cpu_clk_gate_out = ((state == ccs_pkg::ST_INT_OSC) || (state == ccs_pkg::ST_SYS_CLK))
                            && !gap_busy;
  assign cpu_on_main_out = mcm_reg[ccs_pkg::MCM_STATE_BIT];
  assign main_osc_run_out = !moc_reg[ccs_pkg::MOC_HALT_BIT] && (state != ccs_pkg::ST_STOP);
  // halting the internal oscillator takes effect only once off it
  assign int_osc_run_out = !(rosc_reg[ccs_pkg::ROSC_HALT_BIT] && mcm_reg[ccs_pkg::MCM_STATE_BIT])
                           && (state != ccs_pkg::ST_STOP);
  assign osc_mode_reg_out = osc_reg;
  assign main_osc_ctrl_reg_out = moc_reg;
  assign main_clock_mode_reg_out = mcm_reg;
  assign int_osc_mode_reg_out = {!int_osc_run_out, rosc_reg[6:0]};
  assign cpu_clock_ctrl_reg_out = {cpu_reg[7:6], 1'b0, cpu_reg[4:0]};
  assign state_out = state;

  // helper for the gap check: cycles withheld since the last gain raise, saturating
  logic [ccs_pkg::CNT_W-1:0] gap_seen, next_gap_seen;
  always_comb begin
    next_gap_seen = gap_seen;
    if (amp_load) begin
      next_gap_seen = '0;
    end else if (!cpu_clk_gate_out && (gap_seen != '1)) begin
      next_gap_seen = gap_seen + ccs_pkg::CNT_W'(1);
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      gap_seen <= '0;
    end else if (clk_en_in) begin
      gap_seen <= next_gap_seen;
    end
  end

  // a gain raise taken on an enabled edge
  sequence gain_raise_s;
    clk_en_in && amp_load;
  endsequence
  // main path and main select both set on an enabled edge
  sequence main_armed_s;
    clk_en_in && mcm_reg[ccs_pkg::MCM_SRC_BIT] && mcm_reg[ccs_pkg::MCM_PATH_BIT];
  endsequence
  // the cpu clock comes back once the gain flag has been settled
  sequence gate_back_s;
    amp_done && $rose(cpu_clk_gate_out);
  endsequence

  amp_gap_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    gain_raise_s |=> !cpu_clk_gate_out [*8]) else $error("cpu clock not withheld");
  gap_length_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    gate_back_s |-> gap_seen >= ccs_pkg::CNT_W'(ccs_pkg::AMP_GAP_CYC))
    else $error("cpu clock gap too short");
  amp_once_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    amp_done && clk_en_in |=> $stable(osc_reg[ccs_pkg::OSC_AMP_BIT]))
    else $error("gain flag changed twice");
  path_once_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    path_done && clk_en_in |=> $stable(mcm_reg[ccs_pkg::MCM_PATH_BIT]))
    else $error("path flag changed twice");
  no_return_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    cpu_on_main_out |=> cpu_on_main_out) else $error("cpu returned to internal clock");
  halt_entry_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    clk_en_in && state == ccs_pkg::ST_SYS_CLK && halt_instr_in && !stop_instr_in
    |=> state == ccs_pkg::ST_HALT) else $error("halt not entered");
  pre_reset_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    state == ccs_pkg::ST_PRE_RESET && voltage_detect_option_in && !supply_trip_in
    |=> state == ccs_pkg::ST_PRE_RESET) else $error("left pre-reset early");
  main_flag_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    main_armed_s |=> cpu_on_main_out) else $error("status lag");
  int_start_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    state == ccs_pkg::ST_INT_OSC |-> !cpu_on_main_out) else $error("wrong start clock");
  int_keep_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    !cpu_on_main_out && state != ccs_pkg::ST_STOP |-> int_osc_run_out)
    else $error("internal oscillator stopped too early");
endmodule

// >>> bench/ccs_osc_model.sv
// far side model: supply detector and main oscillator settling
`timescale 1ns/1ps
module ccs_osc_model #(
  parameter int SETTLE_CYC = 64
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  // oscillator and supply
  input wire logic main_osc_run_in,
  input wire logic supply_up_in,
  output logic supply_trip_out,
  output logic settled_out
);
  int cnt;
  always_ff @(posedge core_clk_in) begin
    supply_trip_out <= supply_up_in;
    if (sys_rst_in || !main_osc_run_in) begin
      cnt <= 0;
    end else if (cnt < SETTLE_CYC) begin
      cnt <= cnt + 1;
    end
  end
  // settle flag rises only after a full run, so an early path write would show
  assign settled_out = (cnt == SETTLE_CYC);
endmodule

// >>> bench/ccs_clock_switch_tb.sv
// self-checking bench for the cpu clock source switch
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module ccs_clock_switch_tb;
  logic clk = 0, rst = 1, en = 1, opt = 0, sup = 0, hlt = 0, stp = 0, wak = 0;
  ccs_pkg::ccs_wr_type wr = '0;
  logic [7:0] osc, main_osc_ctrl_reg, main_clock_mode_reg, rosc, cpu;
  logic gate, on_main, mrun, irun, trip, settled;
  logic [2:0] st;
  int err_count = 0, check_count = 0, cyc = 0, seed = 26407, n;
  int m_gain, m_path, m_src, lk_o, lk_m;
  ccs_clock_switch DUT (.core_clk_in(clk), .sys_rst_in(rst), .clk_en_in(en),
    .reg_wr_in(wr), .halt_instr_in(hlt), .stop_instr_in(stp), .wake_in(wak),
    .voltage_detect_option_in(opt), .supply_trip_in(trip), .osc_mode_reg_out(osc),
    .main_osc_ctrl_reg_out(main_osc_ctrl_reg), .main_clock_mode_reg_out(main_clock_mode_reg),
    .int_osc_mode_reg_out(rosc), .cpu_clock_ctrl_reg_out(cpu), .cpu_clk_gate_out(gate),
    .cpu_on_main_out(on_main), .main_osc_run_out(mrun), .int_osc_run_out(irun),
    .state_out(st));
  ccs_osc_model osc_model (.core_clk_in(clk), .sys_rst_in(rst), .main_osc_run_in(mrun),
    .supply_up_in(sup), .supply_trip_out(trip), .settled_out(settled));
  initial begin
    forever #25 clk = ~clk;
  end
  function automatic int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  // reset with the once-only model flags cleared; wait_run then counts cycles to the running state
  task automatic do_reset(input logic o);
    m_gain = 0;
    m_path = 0;
    m_src = 0;
    lk_o = 0;
    lk_m = 0;
    opt = o;
    rst = 1;
    tick(3);
    rst = 0;
  endtask
  task automatic wait_run();
    n = 0;
    while (st !== ccs_pkg::ST_INT_OSC && n < 1000) begin
      tick(1);
      n++;
    end
    `CHK(n >= ccs_pkg::RST_PROC_CYC && n < ccs_pkg::RST_PROC_CYC + 4, 1'b1)
    `CHK(gate, 1'b1)
  endtask
  task automatic wr_reg(input logic [2:0] sel, input logic [7:0] d);
    tick(1);
    wr = '{1'b1, sel, d};
    tick(1);
    wr = '0;
    if (sel == ccs_pkg::SEL_OSC && !lk_o) begin
      m_gain = d[0];
    end
    if (sel == ccs_pkg::SEL_MCM && !lk_m) begin
      m_path = d[2];
    end
    if (sel == ccs_pkg::SEL_MCM && !(m_path && m_src && lk_m)) begin
      m_src = d[0];
    end
    lk_o |= (sel == ccs_pkg::SEL_OSC);
    lk_m |= (sel == ccs_pkg::SEL_MCM);
  endtask
  task automatic pulse(input logic h, input logic s, input logic [2:0] e);
    hlt = h;
    stp = s;
    tick(1);
    hlt = 0;
    stp = 0;
    tick(2);
    `CHK(st, e)
    `CHK({mrun, gate}, {e != ccs_pkg::ST_STOP, 1'b0})
    wak = 1;
    tick(1);
    wak = 0;
    tick(2);
    `CHK(st, ccs_pkg::ST_SYS_CLK)
  endtask
  initial begin
    do_reset(0);
    wait_run();
    `CHK({osc, main_osc_ctrl_reg, main_clock_mode_reg, rosc, cpu}, {ccs_pkg::OSC_RESET, ccs_pkg::MOC_RESET,
      ccs_pkg::MCM_RESET, ccs_pkg::ROSC_RESET, ccs_pkg::CPU_RESET})
    `CHK({mrun, irun}, 2'h1)
    // a write while the enable is low is not taken and nothing moves
    en = 0;
    wr_reg(ccs_pkg::SEL_ROSC, 8'(xs()) | 8'h01);
    tick(1 + (xs() & 7));
    en = 1;
    `CHK({st, rosc}, {ccs_pkg::ST_INT_OSC, ccs_pkg::ROSC_RESET})
    // an early halt request is held off while the cpu still needs the oscillator
    wr_reg(ccs_pkg::SEL_ROSC, 8'h01);
    `CHK({rosc[7], rosc[0], irun}, 3'h3)
    wr_reg(ccs_pkg::SEL_ROSC, 8'h00);
    wr_reg(ccs_pkg::SEL_OSC, 8'h41);
    n = 0;
    while (!gate && n < 1000) begin
      tick(1);
      n++;
    end
    `CHK(n, ccs_pkg::AMP_GAP_CYC)
    wr_reg(ccs_pkg::SEL_MOC, 8'h00);
    n = 0;
    while (!settled && n < 500) begin
      tick(1);
      n++;
    end
    `CHK({settled, mrun}, 2'h3)
    wr_reg(ccs_pkg::SEL_MCM, 8'h05);
    tick(3);
    `CHK({main_clock_mode_reg[2:0], on_main}, 4'hF)
    wr_reg(ccs_pkg::SEL_OSC, 8'h80);
    tick(2);
    `CHK({osc[7:6], osc[0], gate}, {2'h2, m_gain[0], 1'b1})
    // refused writes keep the path and the main select whatever else they carry
    wr_reg(ccs_pkg::SEL_MCM, 8'(xs()) & 8'hFA);
    tick(2);
    `CHK({main_clock_mode_reg[2], main_clock_mode_reg[0], on_main}, {m_path[0], m_src[0], 1'b1})
    `CHK(irun, 1'b1)
    wr_reg(ccs_pkg::SEL_ROSC, 8'h01);
    tick(2);
    `CHK({rosc[7], rosc[0], irun}, 3'h6)
    pulse(1, 0, ccs_pkg::ST_HALT);
    pulse(1, 1, ccs_pkg::ST_STOP);
    do_reset(1);
    tick(50);
    `CHK({st, gate}, {ccs_pkg::ST_PRE_RESET, 1'b0})
    sup = 1;
    wait_run();
    // external input: no settle wait and no gap with the gain left low
    wr_reg(ccs_pkg::SEL_OSC, 8'hC0);
    wr_reg(ccs_pkg::SEL_MOC, 8'h00);
    wr_reg(ccs_pkg::SEL_MCM, 8'h05);
    tick(3);
    `CHK({osc[7:6], osc[0], gate, on_main}, {2'h3, m_gain[0], 2'h3})
    wr_reg(ccs_pkg::SEL_CPU, 8'h11);
    tick(2);
    `CHK(cpu, 8'h11)
    stop_test();
  end
endmodule
